// ===== design/fms_pkg.sv
/*
 Package for the flash mode select and self-program control block.
 Holds mode encodings, strap and link carriers, timing counts.
 Assumes a single 40 MHz system clock and active-low async reset.
*/
package fms_pkg;

    localparam int FMS_FWIN_STD     = 14974;
    localparam int FMS_FWIN_FAST    = 11994;
    localparam int FMS_HANDLER_MAX  = 10;
    localparam int FMS_SLOT_W       = 4;
    localparam logic [1:0] FMS_RESET_PIN_STATE = 2'h0;

    typedef enum logic [1:0] {
        FMS_MODE_NORMAL = 2'b00,
        FMS_MODE_EXTPRG = 2'b01,
        FMS_MODE_PROHIB = 2'b10
    } fms_mode_t;

    typedef enum logic [2:0] {
        FMS_LINK_NONE   = 3'b000,
        FMS_LINK_ASYNC  = 3'b001,
        FMS_LINK_CSI0   = 3'b010,
        FMS_LINK_CSI3   = 3'b011,
        FMS_LINK_CSI0HS = 3'b100,
        FMS_LINK_CSI3HS = 3'b101
    } fms_link_t;

    typedef struct packed {
        logic primary_mode_strap;
        logic auxiliary_mode_strap;
    } fms_strap_t;

    typedef struct packed {
        logic irq_req;
        logic nmi_req;
    } fms_irq_t;

endpackage : fms_pkg

// ===== design/fms_ctrl.sv
/*
 Flash mode select and self-program control: strap latch, firmware
 window, write protect, boot swap, link pins and interrupt dispatch.
 Assumes straps and requests synchronous to sys_clk; reset release is
 seen as the first clocked edge with resetn high.
*/
// Overview of operation
// R1: primary low normal; high/aux low programming
// R2: auxiliary strap ignored while primary is low
// R3: rewrite allowed only while primary strap high
// R4: software returns primary strap low afterwards
// R5: firmware window after reset; strap held low
// R6: unused pins keep reset state in programming
// R7: boot swap exchanges blocks 0/1 with 2/3
// R8: interrupts serviced during flash operation
// R9: ten simple handlers, later ones slower
// R10: custom mode vector sits at RAM start
// R11: handlers registered before flash operations; the code also accepts them while a flash operation is in progress
// R12: programming link pins per selected serial unit
// R13: debug reset held low or open in programming
// R14: only programmer drives reset in programming
// R15: straps sampled once at release, then latched
`timescale 1ns/100ps
module fms_ctrl
    import fms_pkg::*;
#(
    parameter int FWIN_CYCLES = FMS_FWIN_STD,
    parameter int HANDLERS    = FMS_HANDLER_MAX
)(
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               resetn,
    // Straps and link selection
    input  wire fms_strap_t         strap,
    input  wire fms_link_t          link_sel,
    // Self-programming requests
    input  wire logic               rewrite_req,
    input  wire logic               swap_boot_area,
    input  wire logic               register_user_irq_handler,
    input  wire fms_irq_t           irq_in,
    // Status
    output fms_mode_t               mode,
    output logic                    mode_valid,
    output logic                    fw_busy,
    output logic                    rewrite_grant,
    output logic                    swap_active,
    output logic                    pins_reset_state,
    output logic [5:0]              link_pin_en,
    output logic [FMS_SLOT_W-1:0]   handler_count,
    output logic [FMS_SLOT_W-1:0]   dispatch_wait,
    output logic                    irq_ack
);

    localparam int CW = $clog2(FWIN_CYCLES + 1);
    logic          sampled;
    logic [CW-1:0] fw_cnt;
    logic          flash_busy;
    logic [FMS_SLOT_W-1:0] wait_cnt;

    // Straps taken on the first edge after release, held until reset
    always_ff @(posedge sys_clk or negedge resetn)
        if (!resetn)
        begin
            sampled    <= 1'b0;
            mode       <= FMS_MODE_NORMAL;
            mode_valid <= 1'b0;
        end
        else if (!sampled)
        begin
            sampled    <= 1'b1;                               // [R15]
            mode_valid <= 1'b1;
            if (!strap.primary_mode_strap)
                mode <= FMS_MODE_NORMAL;                      // [R1] [R2]
            else if (!strap.auxiliary_mode_strap)
                mode <= FMS_MODE_EXTPRG;                      // [R1]
            else
                mode <= FMS_MODE_PROHIB;                      // [R1]
        end

    // Boot-swap firmware window; no rewrite grant or boot swap until it ends
    always_ff @(posedge sys_clk or negedge resetn)
        if (!resetn)
        begin
            fw_cnt  <= '0;
            fw_busy <= 1'b1;
        end
        else if (fw_busy)
        begin
            if (fw_cnt == CW'(FWIN_CYCLES - 1))
                fw_busy <= 1'b0;                              // [R5]
            fw_cnt <= fw_cnt + 1'b1;
        end

    // Write protect follows the live primary strap
    always_ff @(posedge sys_clk or negedge resetn)
        if (!resetn)
        begin
            rewrite_grant <= 1'b0;
            flash_busy    <= 1'b0;
        end
        else
        begin
            rewrite_grant <= rewrite_req && !fw_busy
                && mode == FMS_MODE_NORMAL
                && strap.primary_mode_strap;                  // [R3]
            flash_busy <= rewrite_req && strap.primary_mode_strap;
        end

    // Swap toggles on every cycle that the request is high in normal mode after the window; the boot region flips with it
    always_ff @(posedge sys_clk or negedge resetn)
        if (!resetn)
            swap_active <= 1'b0;
        else if (swap_boot_area && !fw_busy && mode == FMS_MODE_NORMAL)
            swap_active <= ~swap_active;                      // [R7]

    // In programming mode, unused pins frozen at reset state and link pins set by serial unit
    always_ff @(posedge sys_clk or negedge resetn)
        if (!resetn)
        begin
            pins_reset_state <= 1'b0;
            link_pin_en      <= '0;
        end
        else
        begin
            pins_reset_state <= (mode == FMS_MODE_EXTPRG);    // [R6]
            link_pin_en <= '0;
            if (mode == FMS_MODE_EXTPRG)
                unique case (link_sel)                        // [R12]
                    FMS_LINK_ASYNC:  link_pin_en <= 6'h03;
                    FMS_LINK_CSI0:   link_pin_en <= 6'h07;
                    FMS_LINK_CSI3:   link_pin_en <= 6'h38;
                    FMS_LINK_CSI0HS: link_pin_en <= 6'h0F;
                    FMS_LINK_CSI3HS: link_pin_en <= 6'h3C;
                    default:         link_pin_en <= '0;
                endcase
        end

    // Simple-mode handler table: each later slot costs one more cycle
    always_ff @(posedge sys_clk or negedge resetn)
        if (!resetn)
            handler_count <= '0;
        else if (register_user_irq_handler
                 && handler_count < FMS_SLOT_W'(HANDLERS))
            handler_count <= handler_count + 1'b1;            // [R9] [R11]

    // Interrupts served even mid-operation; latency grows with slots
    always_ff @(posedge sys_clk or negedge resetn)
        if (!resetn)
        begin
            wait_cnt      <= '0;
            dispatch_wait <= '0;
            irq_ack       <= 1'b0;
        end
        else
        begin
            irq_ack <= 1'b0;
            if (wait_cnt != '0)
            begin
                wait_cnt <= wait_cnt - 1'b1;
                if (wait_cnt == FMS_SLOT_W'(1))
                    irq_ack <= 1'b1;                          // [R8]
            end
            else if ((irq_in.irq_req || irq_in.nmi_req)
                     && handler_count != '0)
            begin
                wait_cnt      <= handler_count;               // [R9]
                dispatch_wait <= handler_count;
            end
        end

    // Checks are silenced while reset is low; $past then sees reset values
    fw_window_a: assert property ( // [R5]
        @(posedge sys_clk) disable iff (!resetn)
        $fell(fw_busy) |-> fw_cnt == CW'(FWIN_CYCLES))
        else $error("firmware window length wrong");
    fw_quiet_a: assert property ( // [R5]
        @(posedge sys_clk) disable iff (!resetn)
        fw_busy |=> !rewrite_grant)
        else $error("rewrite granted inside firmware window");
    grant_strap_a: assert property ( // [R3]
        @(posedge sys_clk) disable iff (!resetn)
        rewrite_grant |-> $past(strap.primary_mode_strap))
        else $error("rewrite granted with strap low");
    mode_held_a: assert property ( // [R15]
        @(posedge sys_clk) disable iff (!resetn)
        mode_valid && $past(mode_valid) |-> $stable(mode))
        else $error("latched mode changed");
    mode_sel_a: assert property ( // [R1]
        @(posedge sys_clk) disable iff (!resetn)
        $rose(mode_valid) && !$past(strap.primary_mode_strap)
        |-> mode == FMS_MODE_NORMAL)
        else $error("low primary strap not normal");
    aux_ignore_a: assert property ( // [R2]
        @(posedge sys_clk) disable iff (!resetn)
        $rose(mode_valid) && !$past(strap.primary_mode_strap)
        && $past(strap.auxiliary_mode_strap) |-> mode == FMS_MODE_NORMAL)
        else $error("auxiliary strap not ignored");
    prohib_sel_a: assert property ( // [R1]
        @(posedge sys_clk) disable iff (!resetn)
        $rose(mode_valid) && $past(strap.primary_mode_strap)
        && $past(strap.auxiliary_mode_strap) |-> mode == FMS_MODE_PROHIB)
        else $error("prohibited straps not flagged");
    pins_frz_a: assert property ( // [R6]
        @(posedge sys_clk) disable iff (!resetn)
        mode_valid && mode == FMS_MODE_EXTPRG |=> pins_reset_state)
        else $error("pins not frozen in programming");
    irq_lat_a: assert property ( // [R8]
        @(posedge sys_clk) disable iff (!resetn)
        wait_cnt == '0 && (irq_in.irq_req || irq_in.nmi_req)
        && handler_count == FMS_SLOT_W'(1) |=> ##1 irq_ack)
        else $error("interrupt not served in time");
    slot_cap_a: assert property ( // [R9]
        @(posedge sys_clk) disable iff (!resetn)
        handler_count <= FMS_SLOT_W'(HANDLERS))
        else $error("handler count over limit");
    swap_cond_a: assert property ( // [R7]
        @(posedge sys_clk) disable iff (!resetn)
        $changed(swap_active) |-> $past(swap_boot_area) && !$past(fw_busy))
        else $error("swap outside request");
    link_off_a: assert property ( // [R12]
        @(posedge sys_clk) disable iff (!resetn)
        mode_valid && mode != FMS_MODE_EXTPRG |=> link_pin_en == '0)
        else $error("link pins in wrong mode");

    swap_c: cover property (@(posedge sys_clk) disable iff (!resetn)
        $rose(swap_active));
    grant_c: cover property (@(posedge sys_clk) disable iff (!resetn)
        rewrite_grant && flash_busy);
    prog_c: cover property (@(posedge sys_clk) disable iff (!resetn)
        $rose(mode_valid) ##0 mode == FMS_MODE_EXTPRG);
    ack_c: cover property (@(posedge sys_clk) disable iff (!resetn)
        irq_ack && flash_busy);

endmodule : fms_ctrl

// ===== tb/fms_prog_model.sv
/*
 Behavioural flash programmer facing the mode straps and device reset.
 Assumes the bench sets its commands by non-blocking writes at negedge.
*/
`timescale 1ns/100ps
module fms_prog_model
    import fms_pkg::*;
(
    // Clock
    input  wire logic        sys_clk,
    // Commands from the bench
    input  wire logic        rst_req,
    input  wire fms_strap_t  want,
    // Device pins
    output logic             resetn,
    output fms_strap_t       strap
);
    logic [3:0] hold = 4'hA;

    // Only this model drives reset, ten cycles long; the debug unit
    // reset line is never driven high, so it is left open here
    // Custom-mode vectors are software's; no pin stands for them
    always @(negedge sys_clk)
    begin
        if (rst_req)
            hold <= 4'hA;
        else if (hold != 4'h0)
            hold <= hold - 4'h1;
    end
    assign resetn = (hold == 4'h0) && !rst_req;

    // Straps move only when asked; low through the window unless told
    always @(negedge sys_clk)
    begin
        strap <= want;
    end
endmodule : fms_prog_model

// ===== tb/fms_ctrl_tb.sv
/*
 Self-checking bench for the flash mode select block.
 Assumes the programmer model owns reset and the straps.
*/
`timescale 1ns/100ps
module fms_ctrl_tb
    import fms_pkg::*;
;
    localparam int FWIN = 20;
    logic       sys_clk = 1'b0, rst_req = 1'b0;
    logic       rewrite_req = 1'b0, swap_req = 1'b0, reg_req = 1'b0;
    fms_strap_t want = '0, strap;
    fms_link_t  link_sel = FMS_LINK_NONE;
    fms_irq_t   irq_in = '0;
    fms_mode_t  mode;
    logic       resetn, mode_valid, fw_busy, rewrite_grant;
    logic       swap_active, pins_reset_state, irq_ack;
    logic [5:0] link_pin_en;
    logic [3:0] handler_count, dispatch_wait;
    int         n_errors = 0, check_count = 0;

    always #12.5 sys_clk = ~sys_clk;

    fms_prog_model prog_u (.sys_clk, .rst_req, .want, .resetn, .strap);
    fms_ctrl #(.FWIN_CYCLES(FWIN)) dut_u (.sys_clk, .resetn, .strap,
        .link_sel, .rewrite_req, .swap_boot_area(swap_req),
        .register_user_irq_handler(reg_req), .irq_in, .mode, .mode_valid,
        .fw_busy, .rewrite_grant, .swap_active, .pins_reset_state,
        .link_pin_en, .handler_count, .dispatch_wait, .irq_ack);

    task tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick
    task chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task give_verdict;
        $display("Checks %0d, errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict
    task do_reset(input fms_strap_t s);
        want <= s;
        rst_req <= 1'b1;
        tick(1);
        rst_req <= 1'b0;
        @(posedge resetn);
        tick(1);
        chk(mode_valid, 8'h01);
    endtask : do_reset
    task t_modes;
        fms_mode_t e;
        for (int i = 0; i < 4; i++)
        begin
            e = (i < 2) ? FMS_MODE_NORMAL
              : (i == 2) ? FMS_MODE_EXTPRG : FMS_MODE_PROHIB;
            do_reset(fms_strap_t'(i[1:0]));
            chk(mode, e);
            // Freeze flag trails the latched mode by one edge
            tick(1);
            chk(pins_reset_state, 8'(i == 2));
            want <= fms_strap_t'(i[1:0] ^ 2'h1);
            tick(3);
            chk(mode, e);
        end
    endtask : t_modes
    task t_links;
        logic [5:0] exp [6] = '{6'h00, 6'h03, 6'h07, 6'h38, 6'h0F, 6'h3C};
        do_reset(fms_strap_t'(2'h2));
        for (int i = 0; i < 6; i++)
        begin
            link_sel <= fms_link_t'(i[2:0]);
            tick(2);
            chk(link_pin_en, exp[i]);
        end
    endtask : t_links
    task t_rewrite;
        int n;
        do_reset('0);
        for (n = 1; fw_busy === 1'b1 && n < 100; n++) tick(1);
        chk(8'(n), 8'(FWIN));
        rewrite_req <= 1'b1;
        tick(2);
        chk(rewrite_grant, 8'h00);
        want <= fms_strap_t'(2'h2);
        tick(3);
        chk(rewrite_grant, 8'h01);
        want <= '0;
        tick(3);
        chk(rewrite_grant, 8'h00);
        rewrite_req <= 1'b0;
    endtask : t_rewrite
    task t_swap(input int len, input logic exp);
        swap_req <= 1'b1;
        tick(len);
        swap_req <= 1'b0;
        tick(2);
        chk(swap_active, 8'(exp));
    endtask : t_swap
    task add_handler(input int n);
        repeat (n)
        begin
            reg_req <= 1'b1;
            tick(1);
            reg_req <= 1'b0;
            tick(1);
        end
    endtask : add_handler
    task fire(input logic [1:0] v, input int exp);
        int k;
        irq_in <= fms_irq_t'(v);
        tick(1);
        irq_in <= '0;
        for (k = 1; irq_ack !== 1'b1 && k < 30; k++) tick(1);
        chk(8'(k), 8'(exp));
    endtask : fire
    task t_irq;
        logic seen = 1'b0;
        irq_in <= fms_irq_t'(2'h2);
        tick(1);
        irq_in <= '0;
        repeat (4) begin tick(1); seen |= (irq_ack === 1'b1); end
        chk(8'(seen), 8'h00);
        // Dispatch is exercised while a rewrite is in progress
        rewrite_req <= 1'b1;
        want <= fms_strap_t'(2'h2);
        add_handler(1);
        fire(2'h2, 2);
        chk(dispatch_wait, 8'h01);
        add_handler(11);
        chk(handler_count, 8'h0A);
        fire(2'h1, 11);
        chk(dispatch_wait, 8'h0A);
        chk(rewrite_grant, 8'h01);
        rewrite_req <= 1'b0;
        want <= '0;
    endtask : t_irq

    initial
    begin
        tick(1);
        t_modes();
        t_links();
        t_rewrite();
        t_swap(1, 1'b1);
        t_swap(2, 1'b1);
        t_irq();
        give_verdict();
    end
    // Whole run needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        n_errors++;
        give_verdict();
    end
endmodule : fms_ctrl_tb
